// ===== hdl/msp_bank.sv
// motion set-point parameter bank: object entries, offsets, interpolation take-over and cycle time
// Function
// - bits 8..15 of the velocity unit descriptor give the time unit code
// - bits 16..23 of the velocity unit descriptor give the position unit code
// - bits 24..31 of the velocity unit descriptor give a power-of-ten exponent
// - position offset is added to the position set value in cyclic synchronous position
// - velocity offset is added to speed set value in csp, csv and clock-direction
// - signed 16-bit torque offset added to torque set value in csp, csv, cst, clock-direction
// - interpolation set-point is the demand position in interpolated position mode
// - a written interpolation set-point takes effect only at the next sync event
// - cycle time is counted only for exponent -3, as the period value in milliseconds in clock cycles; other exponents give zero
`timescale 1ns/1ns
`default_nettype none
`include "msp_params.svh"
module msp_bank
(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_resetn,
  input  wire msp_pkg::msp_access_type i_acc,
  input  wire logic                    i_sync,
  input  wire msp_pkg::msp_mode_type   i_mode,
  input  wire msp_pkg::msp_setval_type i_setval,
  output logic [31:0]                  o_rdata,
  output logic                         o_rvalid,
  output logic                         o_ack,
  output logic                         o_err,
  output msp_pkg::msp_setval_type      o_demand,
  output msp_pkg::msp_vel_unit_type    o_vel_unit,
  output logic [31:0]                  o_cycle_cycles,
  output logic                         o_cycle_ms_base
);

  logic [31:0] vel_unit_ff;
  logic [31:0] pos_ofs_ff;
  logic [31:0] vel_ofs_ff;
  logic [15:0] trq_ofs_ff;
  logic [31:0] ip_written_ff;
  logic [31:0] ip_active_ff;
  logic [7:0]  ip_period_ff;
  logic [7:0]  ip_exp_ff;
  logic [31:0] nxt_rdata;
  logic        nxt_hit;
  logic        nxt_ro;
  msp_pkg::msp_setval_type nxt_demand;

  // decodes one object entry; used by the write path only, the read mux decodes the index itself
  function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                               input logic [15:0] want_idx, input logic [7:0] want_sub);
    hit = (idx == want_idx) && (sub == want_sub);
  endfunction

  logic wr_vu;
  logic wr_po;
  logic wr_vo;
  logic wr_to;
  logic wr_ip;
  logic wr_pv;
  logic wr_pe;
  assign wr_vu = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_VEL_UNIT, `MSP_SUB_COUNT);
  assign wr_po = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_POS_OFS, `MSP_SUB_COUNT);
  assign wr_vo = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_VEL_OFS, `MSP_SUB_COUNT);
  assign wr_to = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_TRQ_OFS, `MSP_SUB_COUNT);
  assign wr_ip = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_IP_REC, `MSP_SUB_FIRST);
  assign wr_pv = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_IP_TIME, `MSP_SUB_FIRST);
  assign wr_pe = i_acc.wr && hit(i_acc.index, i_acc.subindex, `MSP_IDX_IP_TIME, `MSP_SUB_SECOND);

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      vel_unit_ff <= `MSP_RST_VEL_UNIT;
    else if (wr_vu)
      vel_unit_ff <= i_acc.wdata & `MSP_VU_RSVD_MASK;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pos_ofs_ff <= `MSP_RST_POS_OFS;
      vel_ofs_ff <= `MSP_RST_VEL_OFS;
      trq_ofs_ff <= `MSP_RST_TRQ_OFS;
    end
    else
    begin
      if (wr_po)
        pos_ofs_ff <= i_acc.wdata;
      if (wr_vo)
        vel_ofs_ff <= i_acc.wdata;
      if (wr_to)
        trq_ofs_ff <= i_acc.wdata[15:0];
    end
  end

  // written value is staged; the motion logic sees it only after a sync
  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ip_written_ff <= `MSP_RST_IP_SETPOINT;
    else if (wr_ip)
      ip_written_ff <= i_acc.wdata;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      ip_active_ff <= `MSP_RST_IP_SETPOINT;
    else if (i_sync)
      ip_active_ff <= wr_ip ? i_acc.wdata : ip_written_ff;
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      ip_period_ff <= `MSP_RST_IP_PERIOD;
      ip_exp_ff    <= `MSP_RST_IP_EXP;
    end
    else
    begin
      if (wr_pv)
        ip_period_ff <= i_acc.wdata[7:0];
      if (wr_pe)
        ip_exp_ff <= i_acc.wdata[7:0];
    end
  end

  // field view of the velocity unit
  assign o_vel_unit.time_unit = vel_unit_ff[`MSP_VU_TIME_LSB +: 8];
  assign o_vel_unit.position  = vel_unit_ff[`MSP_VU_POS_LSB +: 8];
  assign o_vel_unit.exponent  = vel_unit_ff[`MSP_VU_EXP_LSB +: 8];

  // cycle time in clock cycles; only the millisecond base is counted, others give zero
  assign o_cycle_ms_base = (ip_exp_ff == `MSP_EXP_MS);
  assign o_cycle_cycles  = o_cycle_ms_base
                         ? 32'(32'(ip_period_ff) * 32'(`MSP_CYC_PER_MS)) : 32'h00000000;

  always_comb
  begin
    nxt_demand = i_setval;
    unique case (i_mode)
      msp_pkg::MSP_MODE_CSP:
      begin
        nxt_demand.position = i_setval.position + $signed(pos_ofs_ff);
        nxt_demand.velocity = i_setval.velocity + $signed(vel_ofs_ff);
        nxt_demand.torque   = i_setval.torque + $signed(trq_ofs_ff);
      end
      msp_pkg::MSP_MODE_CSV, msp_pkg::MSP_MODE_CD:
      begin
        nxt_demand.velocity = i_setval.velocity + $signed(vel_ofs_ff);
        nxt_demand.torque   = i_setval.torque + $signed(trq_ofs_ff);
      end
      msp_pkg::MSP_MODE_CST:
        nxt_demand.torque = i_setval.torque + $signed(trq_ofs_ff);
      msp_pkg::MSP_MODE_IP:
        nxt_demand.position = $signed(ip_active_ff);
      default:
        nxt_demand = i_setval;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      o_demand <= '0;
    else
      o_demand <= nxt_demand;
  end

  // read mux; sub 0 of the record objects gives the entry count
  always_comb
  begin
    nxt_rdata = 32'h00000000;
    nxt_hit   = 1'b1;
    nxt_ro    = 1'b0;
    unique case (i_acc.index)
      `MSP_IDX_VEL_UNIT:
      begin
        nxt_rdata = vel_unit_ff;
        nxt_hit   = (i_acc.subindex == `MSP_SUB_COUNT);
      end
      `MSP_IDX_POS_OFS:
      begin
        nxt_rdata = pos_ofs_ff;
        nxt_hit   = (i_acc.subindex == `MSP_SUB_COUNT);
      end
      `MSP_IDX_VEL_OFS:
      begin
        nxt_rdata = vel_ofs_ff;
        nxt_hit   = (i_acc.subindex == `MSP_SUB_COUNT);
      end
      `MSP_IDX_TRQ_OFS:
      begin
        nxt_rdata = {{16{trq_ofs_ff[15]}}, trq_ofs_ff};
        nxt_hit   = (i_acc.subindex == `MSP_SUB_COUNT);
      end
      `MSP_IDX_IP_REC:
      begin
        nxt_ro    = (i_acc.subindex == `MSP_SUB_COUNT);
        nxt_rdata = nxt_ro ? `MSP_IP_REC_ENTRIES : ip_written_ff;
        nxt_hit   = (i_acc.subindex <= `MSP_SUB_FIRST);
      end
      `MSP_IDX_IP_TIME:
      begin
        nxt_ro  = (i_acc.subindex == `MSP_SUB_COUNT);
        nxt_hit = (i_acc.subindex <= `MSP_SUB_SECOND);
        if (nxt_ro)
          nxt_rdata = `MSP_IP_TIME_ENTRIES;
        else if (i_acc.subindex == `MSP_SUB_FIRST)
          nxt_rdata = {24'h000000, ip_period_ff};
        else
          nxt_rdata = {{24{ip_exp_ff[7]}}, ip_exp_ff};
      end
      default:
        nxt_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_rdata  <= 32'h00000000;
      o_rvalid <= 1'b0;
      o_ack    <= 1'b0;
      o_err    <= 1'b0;
    end
    else
    begin
      o_rvalid <= i_acc.rd && nxt_hit;
      o_rdata  <= (i_acc.rd && nxt_hit) ? nxt_rdata : 32'h00000000;
      o_ack    <= (i_acc.rd || i_acc.wr) && nxt_hit && !(i_acc.wr && nxt_ro);
      o_err    <= (i_acc.rd || i_acc.wr) && (!nxt_hit || (i_acc.wr && nxt_ro));
    end
  end

  sequence s_ip_written;
    wr_ip && !i_sync;
  endsequence

  sequence s_sync_with_write;
    i_sync && wr_ip;
  endsequence

  sequence s_sync_alone;
    i_sync && !wr_ip;
  endsequence

  a_ip_hold_sync: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    s_ip_written |=> ip_active_ff == $past(ip_active_ff))
    else $error("interpolation set-point changed without sync");
  a_ip_take_new: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    s_sync_with_write |=> ip_active_ff == $past(i_acc.wdata))
    else $error("set-point written with sync not taken");
  a_ip_take_staged: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    s_sync_alone |=> ip_active_ff == $past(ip_written_ff))
    else $error("staged set-point not taken at sync");
  a_vu_reserved_zero: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_vu |=> vel_unit_ff[7:0] == 8'h00 && vel_unit_ff[31:8] == $past(i_acc.wdata[31:8]))
    else $error("velocity unit reserved bits not zero");
  a_vu_read_zero: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_acc.rd && i_acc.index == `MSP_IDX_VEL_UNIT && i_acc.subindex == `MSP_SUB_COUNT |=>
      o_rvalid && o_rdata[7:0] == 8'h00)
    else $error("velocity unit reserved bits read non-zero");
  a_vu_time_field: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_vu |=> o_vel_unit.time_unit == $past(i_acc.wdata[15:8]))
    else $error("velocity time unit field wrong");
  a_vu_pos_field: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_vu |=> o_vel_unit.position == $past(i_acc.wdata[23:16]))
    else $error("velocity position unit field wrong");
  a_vu_exp_field: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    wr_vu |=> o_vel_unit.exponent == $past(i_acc.wdata[31:24]))
    else $error("velocity exponent field wrong");
  a_csp_pos_offset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_mode == msp_pkg::MSP_MODE_CSP && !wr_po |=>
      o_demand.position == 32'($past(i_setval.position) + $past(pos_ofs_ff)))
    else $error("position offset not applied");
  a_pos_no_offset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_mode == msp_pkg::MSP_MODE_CSV || i_mode == msp_pkg::MSP_MODE_CST || i_mode == msp_pkg::MSP_MODE_CD) |=>
      o_demand.position == $past(i_setval.position))
    else $error("position offset applied outside csp");
  a_vel_offset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_mode == msp_pkg::MSP_MODE_CSV || i_mode == msp_pkg::MSP_MODE_CD) |=>
      o_demand.velocity == 32'($past(i_setval.velocity) + $past(vel_ofs_ff)))
    else $error("velocity offset not applied");
  a_csp_vel_offset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_mode == msp_pkg::MSP_MODE_CSP |=>
      o_demand.velocity == 32'($past(i_setval.velocity) + $past(vel_ofs_ff)))
    else $error("velocity offset not applied in csp");
  a_trq_offset: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_mode == msp_pkg::MSP_MODE_CST |=>
      o_demand.torque == 16'($past(i_setval.torque) + $past(trq_ofs_ff)))
    else $error("torque offset not applied");
  a_trq_motion_modes: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    (i_mode == msp_pkg::MSP_MODE_CSP || i_mode == msp_pkg::MSP_MODE_CSV || i_mode == msp_pkg::MSP_MODE_CD) |=>
      o_demand.torque == 16'($past(i_setval.torque) + $past(trq_ofs_ff)))
    else $error("torque offset not applied in motion modes");
  a_ip_demand: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    i_mode == msp_pkg::MSP_MODE_IP |=> o_demand.position == $past(ip_active_ff))
    else $error("interpolation demand wrong");
  a_cycle_time: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ip_exp_ff == `MSP_EXP_MS |-> o_cycle_cycles == 32'(ip_period_ff) * 32'h000186a0)
    else $error("cycle time wrong");
  a_cycle_other: assert property (@(posedge i_ref_clk) disable iff (!i_resetn)
    ip_exp_ff != `MSP_EXP_MS |-> o_cycle_cycles == 32'h00000000)
    else $error("cycle time not zero off the millisecond base");
endmodule
`default_nettype wire

// ===== hdl/msp_params.svh
// offsets, field positions, reset values and timing counts of the motion set-point parameter bank
`ifndef MSP_PARAMS_SVH
`define MSP_PARAMS_SVH
`define MSP_IDX_VEL_UNIT     16'h60a9
`define MSP_IDX_POS_OFS      16'h60b0
`define MSP_IDX_VEL_OFS      16'h60b1
`define MSP_IDX_TRQ_OFS      16'h60b2
`define MSP_IDX_IP_REC       16'h60c1
`define MSP_IDX_IP_TIME      16'h60c2
`define MSP_SUB_COUNT        8'h00
`define MSP_SUB_FIRST        8'h01
`define MSP_SUB_SECOND       8'h02
`define MSP_IP_REC_ENTRIES   32'h00000001
`define MSP_IP_TIME_ENTRIES  32'h00000002
`define MSP_RST_VEL_UNIT     32'h00b44700
`define MSP_RST_POS_OFS      32'h00000000
`define MSP_RST_VEL_OFS      32'h00000000
`define MSP_RST_TRQ_OFS      16'h0000
`define MSP_RST_IP_SETPOINT  32'h00000000
`define MSP_RST_IP_PERIOD    8'h01
`define MSP_RST_IP_EXP       8'hfd
`define MSP_EXP_MS           8'hfd
`define MSP_VU_TIME_LSB      8
`define MSP_VU_POS_LSB       16
`define MSP_VU_EXP_LSB       24
`define MSP_VU_RSVD_MASK     32'hffffff00
`define MSP_CLK_PERIOD_NS    10
`define MSP_NS_PER_MS        1000000
`define MSP_CYC_PER_MS       (`MSP_NS_PER_MS / `MSP_CLK_PERIOD_NS)
`endif

// ===== hdl/msp_pkg.sv
// types of the motion set-point parameter bank
`default_nettype none
package msp_pkg;
  typedef enum logic [3:0]
  {
    MSP_MODE_OFF  = 4'h0,
    MSP_MODE_CSP  = 4'h1,
    MSP_MODE_CSV  = 4'h2,
    MSP_MODE_CST  = 4'h3,
    MSP_MODE_CD   = 4'h4,
    MSP_MODE_IP   = 4'h5
  } msp_mode_type;

  typedef struct packed
  {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] wdata;
  } msp_access_type;

  typedef struct packed
  {
    logic signed [31:0] position;
    logic signed [31:0] velocity;
    logic signed [15:0] torque;
  } msp_setval_type;

  typedef struct packed
  {
    logic [7:0] exponent;
    logic [7:0] position;
    logic [7:0] time_unit;
  } msp_vel_unit_type;
endpackage
`default_nettype wire

// ===== sim/msp_master.sv
// fieldbus master model: object accesses and sync events towards the parameter bank
`timescale 1ns/1ns
`default_nettype none
`include "msp_params.svh"
module msp_master
(
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_ack,
  input  wire logic                    i_err,
  input  wire logic                    i_rvalid,
  input  wire logic [31:0]             i_rdata,
  output var  msp_pkg::msp_access_type o_acc,
  output var  logic                    o_sync
);
  logic [31:0] rdata;
  logic        ack;
  logic        err;
  logic        rv;
  initial
  begin
    o_acc = '0;
    o_sync = 1'b0;
  end
  // request stands for one taken edge, answer captured in the following cycle
  task automatic acc(input logic wr, input logic rd, input logic [15:0] idx, input logic [7:0] sub,
                     input logic [31:0] wd, input logic sy);
    @(posedge i_ref_clk);
    #1;
    o_acc = '{wr: wr, rd: rd, index: idx, subindex: sub, wdata: wd};
    o_sync = sy;
    @(posedge i_ref_clk);
    #1;
    ack = i_ack;
    err = i_err;
    rv = i_rvalid;
    rdata = i_rdata;
    // released fields show the inverse so stale values cannot match
    o_acc = '{wr: 1'b0, rd: 1'b0, index: ~idx, subindex: ~sub, wdata: ~wd};
    o_sync = 1'b0;
  endtask
  // restores the millisecond time base of the interpolation period
  task automatic keep_ms();
    acc(1'b1, 1'b0, `MSP_IDX_IP_TIME, `MSP_SUB_SECOND, {24'h000000, `MSP_EXP_MS}, 1'b0);
  endtask
endmodule
`default_nettype wire

// ===== sim/tb_top.sv
// self-checking bench of the motion set-point parameter bank
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed
  {
    logic        wr;
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [31:0] val;
    logic        err;
  } msp_row_type;
  typedef struct packed
  {
    logic [3:0]  mode;
    logic [31:0] pos;
    logic [31:0] vel;
    logic [15:0] tq;
  } msp_mrow_type;
  logic                      i_ref_clk;
  logic                      i_resetn;
  msp_pkg::msp_access_type   acc;
  logic                      sync;
  msp_pkg::msp_mode_type     mode;
  msp_pkg::msp_setval_type   setval;
  logic [31:0]               rdata;
  logic                      rvalid;
  logic                      ack;
  logic                      err;
  msp_pkg::msp_setval_type   demand;
  msp_pkg::msp_vel_unit_type vel_unit;
  logic [31:0]               cyc;
  logic                      ms_base;
  int                        num_errors = 0;
  int                        cmp_count = 0;
  msp_row_type rows [0:21] = '{
    '{1'b0, 16'h60a9, 8'h00, 32'h00b44700, 1'b0}, '{1'b0, 16'h60b0, 8'h00, 32'h0, 1'b0},
    '{1'b0, 16'h60b2, 8'h00, 32'h0, 1'b0}, '{1'b0, 16'h60c1, 8'h00, 32'h1, 1'b0},
    '{1'b0, 16'h60c2, 8'h01, 32'h1, 1'b0}, '{1'b0, 16'h60c2, 8'h02, 32'hfffffffd, 1'b0},
    '{1'b1, 16'h60a9, 8'h00, 32'h12345678, 1'b0}, '{1'b0, 16'h60a9, 8'h00, 32'h12345600, 1'b0},
    '{1'b1, 16'h60b0, 8'h00, 32'h5, 1'b0}, '{1'b0, 16'h60b0, 8'h00, 32'h5, 1'b0},
    '{1'b1, 16'h60b1, 8'h00, 32'hffffff00, 1'b0}, '{1'b0, 16'h60b1, 8'h00, 32'hffffff00, 1'b0},
    '{1'b1, 16'h60b2, 8'h00, 32'hff9c, 1'b0}, '{1'b0, 16'h60b2, 8'h00, 32'hffffff9c, 1'b0},
    '{1'b1, 16'h60c1, 8'h01, 32'habcd, 1'b0}, '{1'b0, 16'h60c1, 8'h01, 32'habcd, 1'b0},
    '{1'b1, 16'h60c2, 8'h01, 32'h5, 1'b0}, '{1'b0, 16'h60c2, 8'h01, 32'h5, 1'b0},
    '{1'b1, 16'h60c1, 8'h00, 32'h7, 1'b1}, '{1'b1, 16'h60c2, 8'h00, 32'h7, 1'b1},
    '{1'b0, 16'h60c1, 8'h00, 32'h1, 1'b0}, '{1'b0, 16'h6000, 8'h00, 32'h0, 1'b1}};
  msp_mrow_type mrows [0:5] = '{
    '{4'h0, 32'h64, 32'hc8, 16'h000a}, '{4'h1, 32'h69, 32'hffffffc8, 16'hffa6},
    '{4'h2, 32'h64, 32'hffffffc8, 16'hffa6}, '{4'h3, 32'h64, 32'hc8, 16'hffa6},
    '{4'h4, 32'h64, 32'hffffffc8, 16'hffa6}, '{4'h5, 32'h0, 32'hc8, 16'h000a}};
  msp_bank DUT (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_acc(acc), .i_sync(sync), .i_mode(mode),
    .i_setval(setval), .o_rdata(rdata), .o_rvalid(rvalid), .o_ack(ack), .o_err(err), .o_demand(demand),
    .o_vel_unit(vel_unit), .o_cycle_cycles(cyc), .o_cycle_ms_base(ms_base));
  msp_master m (.i_ref_clk(i_ref_clk), .i_ack(ack), .i_err(err), .i_rvalid(rvalid), .i_rdata(rdata),
    .o_acc(acc), .o_sync(sync));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("compares %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    repeat (3000) @(posedge i_ref_clk);
    num_errors++;
    $display("watchdog expired");
    test_done();
  end
  initial
  begin
    i_resetn = 1'b0;
    mode = msp_pkg::MSP_MODE_OFF;
    setval = '{position: 32'sh64, velocity: 32'shc8, torque: 16'sh000a};
    repeat (6) @(posedge i_ref_clk);
    #1;
    chk({8'h00, vel_unit}, 32'h0000b447, "reset unit");
    chk(cyc, 32'h000186a0, "reset cycle");
    chk({ack, err, rvalid, ms_base}, 32'h1, "reset flags");
    i_resetn = 1'b1;
    $display("reset test done");
    for (int i = 0; i < 22; i++)
    begin
      m.acc(rows[i].wr, !rows[i].wr, rows[i].idx, rows[i].sub, rows[i].val, 1'b0);
      chk({m.ack, m.err}, {!rows[i].err, rows[i].err}, "answer");
      if (!rows[i].wr)
      begin
        chk(m.rv, !rows[i].err, "read valid");
        chk(m.rdata, rows[i].val, "read");
      end
    end
    chk({8'h00, vel_unit}, 32'h00123456, "unit fields");
    chk(cyc, 32'h0007a120, "cycle count");
    $display("register table test done");
    for (int i = 0; i < 6; i++)
    begin
      @(posedge i_ref_clk);
      #1;
      mode = msp_pkg::msp_mode_type'(mrows[i].mode);
      repeat (3) @(posedge i_ref_clk);
      #1;
      chk(demand.position, mrows[i].pos, "position");
      chk(demand.velocity, mrows[i].vel, "velocity");
      chk({16'h0000, demand.torque}, {16'h0000, mrows[i].tq}, "torque");
    end
    $display("mode test done");
    m.acc(1'b0, 1'b0, 16'h0000, 8'h00, 32'h0, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(demand.position, 32'habcd, "sync take-over");
    m.acc(1'b1, 1'b0, 16'h60c1, 8'h01, 32'h1234, 1'b1);
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(demand.position, 32'h1234, "write with sync");
    $display("sync test done");
    m.acc(1'b1, 1'b0, 16'h60c2, 8'h02, 32'hfe, 1'b0);
    chk({cyc[30:0], ms_base}, 32'h0, "other exponent");
    m.keep_ms();
    chk({cyc[30:0], ms_base}, {31'h0007a120, 1'b1}, "ms base");
    $display("exponent test done");
    i_resetn = 1'b0;
    #2;
    chk({8'h00, vel_unit}, 32'h0000b447, "second reset");
    @(posedge i_ref_clk);
    #1;
    i_resetn = 1'b1;
    m.acc(1'b0, 1'b1, 16'h60b1, 8'h00, 32'h0, 1'b0);
    chk(m.rdata, 32'h0, "offset after reset");
    $display("second reset test done");
    test_done();
  end
endmodule
`default_nettype wire
